/* File: hdl/cdr_consts.svh */
`ifndef CDR_CONSTS_SVH
`define CDR_CONSTS_SVH
// Register byte offsets
`define CDR_OFF_LOOP 12'h000
`define CDR_OFF_BUF 12'h004
`define CDR_OFF_STAT 12'h008
// Loop control fields
`define CDR_TC_LSB 0
`define CDR_BW_LSB 4
`define CDR_LIM_LSB 8
`define CDR_DLG_LSB 12
`define CDR_HALF_RATE_SEL_BIT 16
`define CDR_QUARTER_RATE_SEL_BIT 17
`define CDR_ALIGN_BIT 20
`define CDR_LOOP_MASK 32'h0013_3777
// Input buffer fields
`define CDR_TERM_BIT 0
`define CDR_FX_BIT 1
`define CDR_OFFAC_BIT 2
`define CDR_OFFDC_BIT 3
`define CDR_THR_LSB 8
`define CDR_BUF_MASK 32'h0000_070f
// Status fields
`define CDR_ST_FREQ_LSB 8
`define CDR_ST_PPM_LSB 16
`define CDR_ST_TCOK_BIT 28
`define CDR_ST_BWOK_BIT 29
// Reset values: time constant 5, bandwidth 5, limit 3, guard 1, full rate
`define CDR_LOOP_RST 32'h0000_1355
// Offset compensation on, level threshold 4
`define CDR_BUF_RST 32'h0000_040c
// Lowest legal codes per rate
`define CDR_TC_MIN_FULL 3'h3
`define CDR_TC_MIN_HALF 3'h2
`define CDR_TC_MIN_QUARTER 3'h1
`define CDR_BW_MIN_FULL 3'h4
`define CDR_BW_MIN_HALF 3'h3
`define CDR_BW_MIN_QUARTER 3'h2
// Loop update divider and integrator scaling
`define CDR_TICK_DIV 8'h04
`define CDR_INTEG_BASE_SHIFT 4'h5
`define CDR_ROT_STEPS 128
`endif

/* File: hdl/cdr_pkg.sv */
package cdr_pkg;
  typedef enum logic [0:0] {
    CDR_BUS_IDLE = 1'b0,
    CDR_BUS_ACK = 1'b1
  } cdr_bus_type;

  typedef struct packed {
    cdr_bus_type bus;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [31:0] loop_reg;
    logic [31:0] buf_reg;
    logic [7:0] div_cnt;
    logic [14:0] phase_acc;
    logic [6:0] ser_phase;
  } cdr_main_type;

  typedef struct packed {
    logic [15:0] acc;
    logic [7:0] freq;
  } cdr_integ_type;
endpackage : cdr_pkg

/* File: hdl/cdr_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module cdr_sync #(
  parameter int W = 2
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } cdr_sync_type;
  cdr_sync_type cur;
  cdr_sync_type next_cur;

  // Two stages; only the second stage is read
  always_comb begin
    next_cur.s1 = async_in;
    next_cur.s2 = cur.s1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign sync_out = cur.s2;
endmodule : cdr_sync
`default_nettype wire

/* File: hdl/cdr_integ.sv */
`timescale 1ns/1ps
`default_nettype none
`include "cdr_consts.svh"
module cdr_integ import cdr_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic tick,
  input wire logic vote_up,
  input wire logic vote_dn,
  input wire logic [3:0] shift,
  input wire logic [7:0] limit,
  output logic [7:0] freq
);
  cdr_integ_type cur;
  cdr_integ_type next_cur;
  logic signed [15:0] acc_n;
  logic signed [15:0] thr;
  logic signed [8:0] lim_s;
  logic signed [8:0] f_n;

  // Net votes build up until the threshold, then the frequency word steps
  always_comb begin
    next_cur = cur;
    thr = $signed(16'h0001 << (shift + `CDR_INTEG_BASE_SHIFT));
    lim_s = $signed({1'b0, limit});
    acc_n = $signed(cur.acc);
    f_n = $signed({cur.freq[7], cur.freq});
    if (tick) begin
      if (vote_up && !vote_dn) begin
        acc_n = acc_n + 16'sd1;
      end else if (vote_dn && !vote_up) begin
        acc_n = acc_n - 16'sd1;
      end
      if (acc_n >= thr) begin
        f_n = f_n + 9'sd1;
        acc_n = 16'sd0;
      end else if (acc_n <= -thr) begin
        f_n = f_n - 9'sd1;
        acc_n = 16'sd0;
      end
    end
    // Saturate at the programmed bounds
    if (f_n > lim_s) begin
      f_n = lim_s;
    end else if (f_n < -lim_s) begin
      f_n = -lim_s;
    end
    next_cur.acc = acc_n;
    next_cur.freq = f_n[7:0];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign freq = cur.freq;

  a_integ_bound: assert property (@(posedge pclk) disable iff (!presetn)
    ($signed(freq) <= $signed({1'b0, $past(limit)}))
    && ($signed(freq) >= -$signed({1'b0, $past(limit)})))
    else $error("integrator outside its bounds");

  a_integ_step: assert property (@(posedge pclk) disable iff (!presetn)
    $stable(limit) && !tick |=> $stable(freq))
    else $error("integrator moved without a tick");
endmodule : cdr_integ
`default_nettype wire

/* File: hdl/cdr_phase_loop.sv */
`timescale 1ns/1ps
`default_nettype none
`include "cdr_consts.svh"
module cdr_phase_loop import cdr_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic pd_early,
  input wire logic pd_late,
  output logic [6:0] rot_phase,
  output logic [6:0] ser_phase,
  output logic ser_phase_align_ena,
  output logic half_rate_sel,
  output logic quarter_rate_sel,
  output logic cm_term_ena,
  output logic ib_fx_mode_ena,
  output logic offset_comp_ac_ena,
  output logic offset_comp_dc_ena,
  output logic [2:0] level_detect_thresh
);
  // Reset image: loop and buffer registers at their defaults, bus idle
  localparam cdr_main_type CDR_MAIN_RST = '{
    bus: CDR_BUS_IDLE,
    pready: 1'b0,
    pslverr: 1'b0,
    prdata: 32'h0000_0000,
    loop_reg: `CDR_LOOP_RST,
    buf_reg: `CDR_BUF_RST,
    div_cnt: 8'h00,
    phase_acc: 15'h0000,
    ser_phase: 7'h00
  };

  // Whole block state and its next value
  cdr_main_type cur;
  cdr_main_type next_cur;
  logic [1:0] votes;
  logic [7:0] freq;
  logic tick;
  logic [2:0] tc_raw;
  logic [2:0] bw_raw;
  logic [2:0] tc_eff;
  logic [2:0] bw_eff;
  logic [2:0] lim_code;
  logic [1:0] guard;
  logic [3:0] integ_shift;
  logic [7:0] integ_limit;
  logic [14:0] prop_frac;
  logic [14:0] delta;
  logic [10:0] ppm_limit;
  logic tc_ok;
  logic bw_ok;
  logic unmapped;
  logic ro_write;
  logic [31:0] rd_word;

  // Lowest legal time constant for the selected rate
  function automatic logic [2:0] cdr_tc_min(input logic h, input logic q);
    cdr_tc_min = q ? `CDR_TC_MIN_QUARTER : (h ? `CDR_TC_MIN_HALF : `CDR_TC_MIN_FULL);
  endfunction : cdr_tc_min

  // Lowest legal bandwidth code for the selected rate
  function automatic logic [2:0] cdr_bw_min(input logic h, input logic q);
    cdr_bw_min = q ? `CDR_BW_MIN_QUARTER : (h ? `CDR_BW_MIN_HALF : `CDR_BW_MIN_FULL);
  endfunction : cdr_bw_min

  // Raise a code to its floor
  function automatic logic [2:0] cdr_floor(input logic [2:0] v, input logic [2:0] lo);
    cdr_floor = (v < lo) ? lo : v;
  endfunction : cdr_floor

  // Compensation limit in ppm by steps above the fastest code
  function automatic logic [10:0] cdr_ppm(input logic [2:0] steps);
    case (steps)
      3'h0: cdr_ppm = 11'd1953;
      3'h1: cdr_ppm = 11'd977;
      3'h2: cdr_ppm = 11'd488;
      3'h3: cdr_ppm = 11'd244;
      3'h4: cdr_ppm = 11'd122;
      default: cdr_ppm = 11'd61;
    endcase
  endfunction : cdr_ppm

  // Phase detector votes come from the sampler and are resynchronised
  cdr_sync #(
    .W(2)
  ) u_vote_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in({pd_early, pd_late}),
    .sync_out(votes)
  );

  // Integral path with its own time constant and bounds
  cdr_integ u_integ (
    .pclk(pclk),
    .presetn(presetn),
    .tick(tick),
    .vote_up(votes[0]),
    .vote_dn(votes[1]),
    .shift(integ_shift),
    .limit(integ_limit),
    .freq(freq)
  );

  // Effective loop settings, clamped to the legal range of the rate
  // Illegal codes run at the floor and read back as cleared flags in status
  always_comb begin
    tc_raw = cur.loop_reg[`CDR_TC_LSB +: 3];
    bw_raw = cur.loop_reg[`CDR_BW_LSB +: 3];
    lim_code = cur.loop_reg[`CDR_LIM_LSB +: 3];
    guard = cur.loop_reg[`CDR_DLG_LSB +: 2];
    tc_eff = cdr_floor(tc_raw, cdr_tc_min(half_rate_sel, quarter_rate_sel));
    bw_eff = cdr_floor(bw_raw, cdr_bw_min(half_rate_sel, quarter_rate_sel));
    tc_ok = (tc_eff == tc_raw);
    bw_ok = (bw_eff == bw_raw);
    ppm_limit = cdr_ppm(bw_eff - cdr_bw_min(half_rate_sel, quarter_rate_sel));
    // Integration exponent follows time constant plus one minus bandwidth
    if ({1'b0, tc_eff} + 4'h1 > {1'b0, bw_eff}) begin
      integ_shift = {1'b0, tc_eff} + 4'h1 - {1'b0, bw_eff};
    end else begin
      integ_shift = 4'h0;
    end
    integ_limit = (8'h01 << lim_code) - 8'h01;
    // Proportional step: lowest code gives the largest step per vote
    prop_frac = 15'h0100 << (3'h7 - bw_eff);
  end

  // Loop update rate
  // Free-running divider; the loop only moves on its one-cycle tick
  assign tick = (cur.div_cnt == `CDR_TICK_DIV - 8'h01);

  // Sum of proportional, integral and guard contributions per update
  // Both votes high cancel out; the late vote advances, the early one retards
  always_comb begin
    delta = {{7{freq[7]}}, freq};
    if (votes[0] && !votes[1]) begin
      delta = delta + prop_frac;
    end else if (votes[1] && !votes[0]) begin
      delta = delta - prop_frac;
    end
    delta = delta + {13'h0000, guard};
  end

  // Register decode
  // Status is read-only, so a write there is refused like an unmapped address
  always_comb begin
    unmapped = 1'b1;
    ro_write = 1'b0;
    rd_word = 32'h0000_0000;
    case (paddr)
      `CDR_OFF_LOOP: begin
        unmapped = 1'b0;
        rd_word = cur.loop_reg;
      end
      `CDR_OFF_BUF: begin
        unmapped = 1'b0;
        rd_word = cur.buf_reg;
      end
      `CDR_OFF_STAT: begin
        unmapped = 1'b0;
        ro_write = pwrite;
        rd_word[6:0] = rot_phase;
        rd_word[`CDR_ST_FREQ_LSB +: 8] = freq;
        rd_word[`CDR_ST_PPM_LSB +: 11] = ppm_limit;
        rd_word[`CDR_ST_TCOK_BIT] = tc_ok;
        rd_word[`CDR_ST_BWOK_BIT] = bw_ok;
      end
      default: begin
        unmapped = 1'b1;
      end
    endcase
  end

  // Bus slave, divider, phase accumulator and serializer alignment
  // A write lands on the edge ending the answer cycle, where the master samples ready
  always_comb begin
    next_cur = cur;
    case (cur.bus)
      CDR_BUS_IDLE: begin
        if (psel && penable) begin
          next_cur.bus = CDR_BUS_ACK;
          next_cur.pready = 1'b1;
          next_cur.pslverr = unmapped || ro_write;
          next_cur.prdata = pwrite ? 32'h0000_0000 : rd_word;
        end
      end
      CDR_BUS_ACK: begin
        next_cur.bus = CDR_BUS_IDLE;
        next_cur.pready = 1'b0;
        next_cur.pslverr = 1'b0;
        next_cur.prdata = 32'h0000_0000;
        if (psel && penable && pwrite && !cur.pslverr) begin
          if (paddr == `CDR_OFF_LOOP) begin
            next_cur.loop_reg = pwdata & `CDR_LOOP_MASK;
          end else if (paddr == `CDR_OFF_BUF) begin
            next_cur.buf_reg = pwdata & `CDR_BUF_MASK;
          end
        end
      end
      default: begin
        next_cur.bus = CDR_BUS_IDLE;
        next_cur.pready = 1'b0;
      end
    endcase
    next_cur.div_cnt = tick ? 8'h00 : cur.div_cnt + 8'h01;
    if (tick) begin
      next_cur.phase_acc = cur.phase_acc + delta;
    end
    // Serializer follows the recovered phase while alignment is on
    if (ser_phase_align_ena) begin
      next_cur.ser_phase = rot_phase;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur <= CDR_MAIN_RST;
    end else begin
      cur <= next_cur;
    end
  end

  // Outputs straight from state
  assign pready = cur.pready;
  assign prdata = cur.prdata;
  assign pslverr = cur.pslverr;
  assign rot_phase = cur.phase_acc[14:8];
  assign ser_phase = cur.ser_phase;
  assign ser_phase_align_ena = cur.loop_reg[`CDR_ALIGN_BIT];
  assign half_rate_sel = cur.loop_reg[`CDR_HALF_RATE_SEL_BIT];
  assign quarter_rate_sel = cur.loop_reg[`CDR_QUARTER_RATE_SEL_BIT];
  assign cm_term_ena = cur.buf_reg[`CDR_TERM_BIT];
  assign ib_fx_mode_ena = cur.buf_reg[`CDR_FX_BIT];
  assign offset_comp_ac_ena = cur.buf_reg[`CDR_OFFAC_BIT];
  assign offset_comp_dc_ena = cur.buf_reg[`CDR_OFFDC_BIT];
  assign level_detect_thresh = cur.buf_reg[`CDR_THR_LSB +: 3];

  a_prop_dominates: assert property (@(posedge pclk) disable iff (!presetn)
    {7'h00, integ_limit} < prop_frac)
    else $error("integrator bound not below proportional step");

  a_tc_range: assert property (@(posedge pclk) disable iff (!presetn)
    (tc_eff >= cdr_tc_min(half_rate_sel, quarter_rate_sel)) && ((tc_raw < 3'h3) || tc_ok))
    else $error("time constant outside legal range");

  a_ppm_fastest: assert property (@(posedge pclk) disable iff (!presetn)
    (bw_raw <= cdr_bw_min(half_rate_sel, quarter_rate_sel)) |-> (ppm_limit == 11'd1953))
    else $error("fastest code does not report 1953 ppm");

  a_bw_speed: assert property (@(posedge pclk) disable iff (!presetn)
    (bw_eff == 3'h7) |-> (prop_frac == 15'h0100))
    else $error("slowest bandwidth step wrong");

  a_guard_moves: assert property (@(posedge pclk) disable iff (!presetn)
    tick && (votes == 2'b00) && (freq == 8'h00) && (guard != 2'h0)
    |=> cur.phase_acc == $past(cur.phase_acc) + {13'h0000, $past(guard)})
    else $error("guard offset not applied");

  a_guard_idle: assert property (@(posedge pclk) disable iff (!presetn)
    tick && (votes == 2'b00) && (freq == 8'h00) && (guard == 2'h0) |=> $stable(cur.phase_acc))
    else $error("phase drifted with guard off");

  a_align_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !ser_phase_align_ena |=> $stable(ser_phase))
    else $error("serializer phase moved without alignment");

  a_integ_rate: assert property (@(posedge pclk) disable iff (!presetn)
    (tc_eff + 3'h1 == bw_eff) |-> (integ_shift == 4'h0))
    else $error("integration exponent wrong");

  // Bus answer: one-cycle ready, error and data only beside it
  a_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("ready held longer than one cycle");

  a_ready_answer: assert property (@(posedge pclk) disable iff (!presetn)
    psel && penable && !pready |=> pready)
    else $error("access not answered in the next cycle");

  a_err_ready: assert property (@(posedge pclk) disable iff (!presetn)
    pslverr |-> pready)
    else $error("error shown without ready");

  a_rdata_idle: assert property (@(posedge pclk) disable iff (!presetn)
    !pready |-> (prdata == 32'h0000_0000))
    else $error("read data not zero outside an answer");

  // Writes land on the answering edge; refused ones leave both registers alone
  a_loop_write: assert property (@(posedge pclk) disable iff (!presetn)
    pready && psel && penable && pwrite && !pslverr && (paddr == `CDR_OFF_LOOP)
    |=> cur.loop_reg == ($past(pwdata) & `CDR_LOOP_MASK))
    else $error("loop register write lost");

  a_buf_write: assert property (@(posedge pclk) disable iff (!presetn)
    pready && psel && penable && pwrite && !pslverr && (paddr == `CDR_OFF_BUF)
    |=> cur.buf_reg == ($past(pwdata) & `CDR_BUF_MASK))
    else $error("buffer register write lost");

  a_refused_keep: assert property (@(posedge pclk) disable iff (!presetn)
    pready && pslverr |=> $stable(cur.loop_reg) && $stable(cur.buf_reg))
    else $error("refused access changed a register");

  // Loop cadence, vote path, serializer tracking and bandwidth floor
  a_tick_period: assert property (@(posedge pclk) disable iff (!presetn)
    tick |-> ##4 tick)
    else $error("loop update period wrong");

  a_vote_sync: assert property (@(posedge pclk) disable iff (!presetn)
    (votes[1] == $past(pd_early, 2)) && (votes[0] == $past(pd_late, 2)))
    else $error("vote synchroniser latency wrong");

  a_ser_follow: assert property (@(posedge pclk) disable iff (!presetn)
    ser_phase_align_ena |=> (ser_phase == $past(rot_phase)))
    else $error("serializer phase not following the loop");

  a_bw_floor: assert property (@(posedge pclk) disable iff (!presetn)
    bw_eff >= cdr_bw_min(half_rate_sel, quarter_rate_sel))
    else $error("bandwidth code below the rate floor");
endmodule : cdr_phase_loop
`default_nettype wire

/* File: tb/cdr_far_tx.sv */
`timescale 1ns/1ps
`default_nettype none
module cdr_far_tx (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [1:0] mode,
  output logic pd_early,
  output logic pd_late
);
  // Remote sender: phase votes change just after the edge, silent in reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pd_early <= 1'b0;
      pd_late <= 1'b0;
    end else begin
      pd_early <= mode[0];
      pd_late <= mode[1];
    end
  end
endmodule : cdr_far_tx
`default_nettype wire

/* File: tb/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "cdr_consts.svh"
module testbench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, sel;
  logic pd_early, pd_late, align, hrs, qrs, term, fx, ofac, ofdc;
  logic [1:0] mode;
  logic [2:0] thr;
  logic [6:0] rot_phase, ser_phase, r0, d;
  int bad_count, n_tests, r, b;
  int ppm[6] = '{1953, 977, 488, 244, 122, 61};

  cdr_far_tx i_far (.pclk(pclk), .presetn(presetn), .mode(mode),
    .pd_early(pd_early), .pd_late(pd_late));

  cdr_phase_loop i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .pd_early(pd_early), .pd_late(pd_late), .rot_phase(rot_phase),
    .ser_phase(ser_phase), .ser_phase_align_ena(align), .half_rate_sel(hrs),
    .quarter_rate_sel(qrs), .cm_term_ena(term), .ib_fx_mode_ena(fx),
    .offset_comp_ac_ena(ofac), .offset_comp_dc_ena(ofdc), .level_detect_thresh(thr));

  // Clock at 100 ns period
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  // Closing report
  task print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : print_verdict

  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc

  // One APB transfer; one idle cycle first so no signal is driven twice at an edge
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] dat);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= dat;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      bad_count++;
      print_verdict();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wr(input logic [11:0] a, input logic [31:0] dat);
    apb(1'b1, a, dat);
    check("write error", err, 1'b0);
  endtask : wr

  task rchk(input string what, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(what, rd, exp);
  endtask : rchk

  // Main sequence
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    mode = 2'h0;
    bad_count = 0;
    n_tests = 0;
    cyc(6);
    presetn <= 1'b1;
    // Reset state of pins and registers
    check("pins", {align, hrs, qrs, term, fx, ofac, ofdc, thr}, 10'h01c);
    check("rot", rot_phase, 7'h00);
    rchk("loop reset", `CDR_OFF_LOOP, 32'h0000_1355);
    rchk("buf reset", `CDR_OFF_BUF, 32'h0000_040c);
    // Guard off, both votes high: phase must not move
    wr(`CDR_OFF_LOOP, 32'h0000_0075);
    rchk("loop back", `CDR_OFF_LOOP, 32'h0000_0075);
    mode <= 2'h3;
    cyc(100);
    check("no vote", rot_phase, 7'h00);
    // Guard on, no votes: phase drifts
    wr(`CDR_OFF_LOOP, 32'h0000_3075);
    mode <= 2'h0;
    cyc(1200);
    check("guard drift", rot_phase != 7'h00, 1'b1);
    // Integrator limit 0: only the proportional step acts; a late vote advances the phase
    wr(`CDR_OFF_LOOP, 32'h0000_0075);
    r0 = rot_phase;
    mode <= 2'h2;
    cyc(400);
    mode <= 2'h0;
    cyc(10);
    d = rot_phase - r0;
    check("up step", d >= 97 && d <= 101, 1'b1);
    apb(1'b0, `CDR_OFF_STAT, 32'h0);
    check("freq at limit 0", rd[15:8], 8'h00);
    // Integrator limit 1: saturates at +1, then at -1
    wr(`CDR_OFF_LOOP, 32'h0000_0175);
    mode <= 2'h2;
    cyc(400);
    apb(1'b0, `CDR_OFF_STAT, 32'h0);
    check("freq up", rd[15:8], 8'h01);
    r0 = rot_phase;
    mode <= 2'h1;
    cyc(400);
    mode <= 2'h0;
    cyc(10);
    d = r0 - rot_phase;
    check("down step", d >= 97 && d <= 101, 1'b1);
    apb(1'b0, `CDR_OFF_STAT, 32'h0);
    check("freq down", rd[15:8], 8'hff);
    // Serializer phase follows the loop when aligned
    check("ser held", ser_phase, 7'h00);
    wr(`CDR_OFF_LOOP, 32'h0010_0175);
    cyc(20);
    check("align pin", align, 1'b1);
    r0 = rot_phase;
    cyc(1);
    check("ser phase", ser_phase, r0);
    // Legal code flags and compensation limits per rate
    for (r = 0; r < 3; r++) begin
      sel = (r == 1) ? 32'h0001_0000 : (r == 2) ? 32'h0002_0000 : 32'h0;
      wr(`CDR_OFF_LOOP, sel | (2 - r) | ((3 - r) << 4));
      apb(1'b0, `CDR_OFF_STAT, 32'h0);
      check("tc flag low", rd[28], 1'b0);
      check("bw flag low", rd[29], 1'b0);
      check("rate pins", {hrs, qrs}, {r == 1, r == 2});
      for (b = 4 - r; b < 8; b++) begin
        wr(`CDR_OFF_LOOP, sel | (3 - r) | (b << 4));
        apb(1'b0, `CDR_OFF_STAT, 32'h0);
        check("tc flag", rd[28], 1'b1);
        check("bw flag", rd[29], 1'b1);
        check("ppm", rd[26:16], ppm[b - 4 + r]);
      end
    end
    // Input buffer controls, reserved bits read as zero
    wr(`CDR_OFF_BUF, 32'hffff_ffff);
    rchk("buf mask", `CDR_OFF_BUF, 32'h0000_070f);
    check("buf pins", {term, fx, ofac, ofdc, thr}, 7'h7f);
    wr(`CDR_OFF_BUF, 32'h0000_0103);
    cyc(1);
    check("fx pins", {term, fx, ofac, ofdc, thr}, 7'h61);
    // Refused accesses leave registers alone
    wr(`CDR_OFF_LOOP, 32'h0000_1355);
    apb(1'b0, 12'h00c, 32'h0);
    check("unmapped err", err, 1'b1);
    apb(1'b1, `CDR_OFF_STAT, 32'hffff_ffff);
    check("stat write err", err, 1'b1);
    apb(1'b1, 12'h010, 32'h0);
    check("unmapped write err", err, 1'b1);
    rchk("loop kept", `CDR_OFF_LOOP, 32'h0000_1355);
    cyc(2);
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
